// >>> pc_seq_regs.vh
// Constants for the program counter sequencer.
`ifndef PC_SEQ_REGS_VH
`define PC_SEQ_REGS_VH
`define PC_WIDTH        13
`define PC_LOW_WIDTH    8
`define PC_HIGH_WIDTH   5
`define PC_JUMP_WIDTH   11
`define PC_PAGE_LSB     3
`define PC_PAGE_MSB     4
`define PC_RESET_VALUE  13'h0000
`define LATCH_RESET     5'h00
`define READ_RESET      8'h00
`define STACK_DEPTH     8
`define STACK_PTR_W     3
`define INT_VECTOR      13'h0004
`endif

// >>> return_stack.v
// Circular return stack with wrap-around pointer and no overflow flag.
`include "pc_seq_regs.vh"
module return_stack
#(
    parameter DEPTH = `STACK_DEPTH,
    parameter PTRW  = `STACK_PTR_W,
    parameter WIDTH = `PC_WIDTH
)
(
    input  wire             clock,    // Core clock.
    input  wire             arst_n,   // Asynchronous reset, active low.
    input  wire             push,     // Push request.
    input  wire             pop,      // Pop request.
    input  wire [WIDTH-1:0] pushData, // Value to push.
    output wire [WIDTH-1:0] topData   // Entry on top of the stack.
);
    reg  [WIDTH-1:0] entry [0:DEPTH-1];
    reg  [PTRW-1:0]  ptr_q;
    wire [PTRW-1:0]  topIdx;
    integer          i;

    assign topIdx  = ptr_q - {{(PTRW-1){1'b0}}, 1'b1};
    assign topData = entry[topIdx];

    // Pointer simply wraps; there is no overflow or underflow state.
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ptr_q <= {PTRW{1'b0}};
            for (i = 0; i < DEPTH; i = i + 1)
                entry[i] <= {WIDTH{1'b0}};
        end
        else if (push)
        begin
            entry[ptr_q] <= pushData; // RULE13
            ptr_q        <= ptr_q + {{(PTRW-1){1'b0}}, 1'b1}; // RULE14
        end
        else if (pop)
        begin
            ptr_q <= topIdx; // RULE14
        end
    end
endmodule // return_stack

// >>> pc_sequencer.v
// Program counter, high-bits latch, paging and return stack control.
//
// Overview of operation
// RULE1: 13-bit counter, low byte read/write.
// RULE2: Upper bits hidden, loaded only via latch.
// RULE3: Any reset clears upper counter bits.
// RULE4: Low-byte write loads latch bits 4:0 high.
// RULE5: Jump/call: 11 instruction bits, latch 4:3.
// RULE6: 8K space in 2K pages.
// RULE7: Software sets page bits before jump/call.
// RULE8: Computed jumps beware 256-word block boundaries.
// RULE9: Hidden 8-deep 13-bit return stack.
// RULE10: Push on call and interrupt vectoring.
// RULE11: Returns pop full 13-bit counter.
// RULE12: Push and pop leave latch unchanged.
// RULE13: Stack is circular; ninth push overwrites first.
// RULE14: No overflow or underflow flags.
// RULE15: Otherwise counter increments per fetch, wrapping.
// RULE16: Low-byte read returns bits 7:0 unchanged.
`include "pc_seq_regs.vh"
module pc_sequencer
#(
    parameter [`PC_WIDTH-1:0] INT_VECTOR = `INT_VECTOR
)
(
    input  wire                      clock,         // Core clock, 40 MHz.
    input  wire                      arst_n,        // Asynchronous reset, active low.
    input  wire                      fetch,         // Fetch step: advance counter.
    input  wire                      jumpDirect,    // Direct jump.
    input  wire                      callDirect,    // Subroutine call.
    input  wire [`PC_JUMP_WIDTH-1:0] jumpTarget,    // 11-bit target from instruction.
    input  wire                      intVector,     // Interrupt branch to vector.
    input  wire                      returnPlain,   // Subroutine return.
    input  wire                      literalBackJump, // Return with literal.
    input  wire                      interruptExit, // Return from interrupt.
    input  wire                      lowWrite,      // Write to counter_low_byte.
    input  wire [`PC_LOW_WIDTH-1:0]  lowWriteData,  // Data for counter_low_byte.
    input  wire                      latchWrite,    // Write to counter_high_latch.
    input  wire [`PC_LOW_WIDTH-1:0]  latchWriteData, // Data for counter_high_latch.
    output reg  [`PC_WIDTH-1:0]      pcOut,         // Program counter.
    output reg  [`PC_LOW_WIDTH-1:0]  lowReadData,   // counter_low_byte read value.
    output reg  [`PC_LOW_WIDTH-1:0]  latchReadData  // counter_high_latch read value.
);
    // ----------------------------------------------------------------
    // Local sizes and request codes
    // ----------------------------------------------------------------
    localparam PCW   = `PC_WIDTH;
    localparam LOWW  = `PC_LOW_WIDTH;
    localparam HIGHW = `PC_HIGH_WIDTH;

    // One-hot code of the request that wins the cycle.
    localparam [5:0] SEL_HOLD   = 6'h01;
    localparam [5:0] SEL_FETCH  = 6'h02;
    localparam [5:0] SEL_LOW    = 6'h04;
    localparam [5:0] SEL_BRANCH = 6'h08;
    localparam [5:0] SEL_POP    = 6'h10;
    localparam [5:0] SEL_VECTOR = 6'h20;

    // ----------------------------------------------------------------
    // Internal state and wires
    // ----------------------------------------------------------------
    reg  [HIGHW-1:0] latch_q;
    reg  [HIGHW-1:0] latch_d;
    reg  [PCW-1:0]   pc_d;
    reg  [5:0]       sel;
    wire [PCW-1:0]   stackTop;
    wire [PCW-1:0]   pcPlusOne;
    wire [PCW-1:0]   returnAddr;
    wire [PCW-1:0]   branchAddr;
    wire [PCW-1:0]   lowAddr;
    wire [LOWW-1:0]  lowRead_d;
    wire [LOWW-1:0]  latchRead_d;
    wire [1:0]       pageBits;
    wire             doPush;
    wire             doPop;
    wire             doBranch;
    genvar           b;

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    assign doPush   = callDirect | intVector; // RULE10
    assign doPop    = returnPlain | literalBackJump | interruptExit; // RULE11
    assign doBranch = jumpDirect | callDirect;

    // Only one request loads the counter per cycle; latch writes and stack pushes from lower requests still act.
    always @*
    begin
        sel = SEL_HOLD;
        if (intVector)
            sel = SEL_VECTOR;
        else if (doPop)
            sel = SEL_POP;
        else if (doBranch)
            sel = SEL_BRANCH;
        else if (lowWrite)
            sel = SEL_LOW;
        else if (fetch)
            sel = SEL_FETCH;
    end

    // ----------------------------------------------------------------
    // Candidate addresses
    // ----------------------------------------------------------------
    // A call saves the address after itself, while an interrupt saves the
    // counter as it stands, since the interrupted fetch has not advanced it.
    assign pageBits   = latch_q[`PC_PAGE_MSB:`PC_PAGE_LSB]; // RULE6
    assign pcPlusOne  = pcOut + {{(PCW-1){1'b0}}, 1'b1}; // RULE15
    assign branchAddr = {pageBits, jumpTarget}; // RULE5
    assign lowAddr    = {latch_q, lowWriteData}; // RULE4
    assign returnAddr = intVector ? pcOut : pcPlusOne;

    // ----------------------------------------------------------------
    // Next counter
    // ----------------------------------------------------------------
    always @*
    begin
        pc_d = pcOut;
        case (sel)
            SEL_VECTOR:
            begin
                pc_d = INT_VECTOR; // RULE10
            end
            SEL_POP:
            begin
                pc_d = stackTop; // RULE11
            end
            SEL_BRANCH:
            begin
                pc_d = branchAddr; // RULE5
            end
            SEL_LOW:
            begin
                pc_d = lowAddr; // RULE2
            end
            SEL_FETCH:
            begin
                pc_d = pcPlusOne; // RULE15
            end
            SEL_HOLD:
            begin
                pc_d = pcOut;
            end
            default:
            begin
                pc_d = pcOut;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // High-bits latch
    // ----------------------------------------------------------------
    // Stack operations never touch the latch.
    always @*
    begin
        latch_d = latch_q; // RULE12
        if (latchWrite)
            latch_d = latchWriteData[HIGHW-1:0];
    end

    // ----------------------------------------------------------------
    // Readback values
    // ----------------------------------------------------------------
    generate
        for (b = 0; b < LOWW; b = b + 1)
        begin : g_readback
            assign lowRead_d[b] = pc_d[b]; // RULE16
            if (b < HIGHW)
            begin : g_latch_bit
                assign latchRead_d[b] = latch_d[b];
            end
            else
            begin : g_pad_bit
                assign latchRead_d[b] = 1'b0;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pcOut <= `PC_RESET_VALUE; // RULE3
        end
        else
        begin
            pcOut <= pc_d; // RULE1
        end
    end

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            latch_q <= `LATCH_RESET;
        end
        else
        begin
            latch_q <= latch_d;
        end
    end

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lowReadData   <= `READ_RESET;
            latchReadData <= `READ_RESET;
        end
        else
        begin
            lowReadData   <= lowRead_d;
            latchReadData <= latchRead_d;
        end
    end

    // ----------------------------------------------------------------
    // Return stack
    // ----------------------------------------------------------------
    return_stack
    #(
        .DEPTH (`STACK_DEPTH),
        .PTRW  (`STACK_PTR_W),
        .WIDTH (`PC_WIDTH)
    )
    u_stack
    (
        .clock    (clock),
        .arst_n   (arst_n),
        .push     (doPush), // RULE9
        .pop      (doPop),
        .pushData (returnAddr),
        .topData  (stackTop)
    );
endmodule // pc_sequencer

// >>> core_decoder_model.sv
// Decoder stand-in that issues one request strobe per clock edge.
module core_decoder_model
(
    input  wire        clock,           // Core clock.
    output wire        fetch,           // Advance strobe.
    output wire        jumpDirect,      // Jump strobe.
    output wire        callDirect,      // Call strobe.
    output wire        intVector,       // Interrupt strobe.
    output wire        returnPlain,     // Return strobe.
    output wire        literalBackJump, // Literal return strobe.
    output wire        interruptExit,   // Interrupt exit strobe.
    output wire        lowWrite,        // Low byte write strobe.
    output wire        latchWrite,      // Latch write strobe.
    output wire [10:0] jumpTarget,      // Jump bits.
    output wire [7:0]  lowWriteData,    // Low byte data.
    output wire [7:0]  latchWriteData   // Latch data.
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [8:0]  s = 9'h000;
    reg [10:0] a = 11'h000;
    assign {latchWrite, lowWrite, interruptExit, literalBackJump, returnPlain, intVector,
            callDirect, jumpDirect, fetch} = s;
    assign jumpTarget = a;
    assign lowWriteData = a[7:0];
    assign latchWriteData = a[7:0];
    task op(input integer k, input integer v);
        s = (k != 0) ? (9'h001 << (k - 1)) : 9'h000;
        a = v[10:0];
        @(posedge clock);
        #2;
    endtask
endmodule // core_decoder_model

// >>> pc_sequencer_assertions.sv
// Port checker for the program counter sequencer.
module pc_sequencer_checker
#(
    parameter [12:0] INT_VECTOR = 13'h0004
)
(
    input wire        clock,           // Core clock.
    input wire        arst_n,          // Reset, active low.
    input wire        fetch,           // Advance strobe.
    input wire        jumpDirect,      // Jump strobe.
    input wire        callDirect,      // Call strobe.
    input wire        intVector,       // Interrupt strobe.
    input wire        returnPlain,     // Return strobe.
    input wire        literalBackJump, // Literal return strobe.
    input wire        interruptExit,   // Interrupt exit strobe.
    input wire        lowWrite,        // Low byte write strobe.
    input wire        latchWrite,      // Latch write strobe.
    input wire [10:0] jumpTarget,      // Jump bits.
    input wire [7:0]  lowWriteData,    // Low byte data.
    input wire [7:0]  latchWriteData,  // Latch data.
    input wire [7:0]  lowReadData,     // Low byte readback.
    input wire [7:0]  latchReadData,   // Latch readback.
    input wire [12:0] pcOut            // Counter.
);
    timeunit 1ns;
    timeprecision 1ps;
    wire pop = returnPlain | literalBackJump | interruptExit;
    wire jmp = (jumpDirect | callDirect) & ~intVector & ~pop;
    wire other = jumpDirect | callDirect | intVector | pop;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_call; jmp && callDirect ##1 returnPlain && !intVector; endsequence
    sequence s_int; intVector ##1 interruptExit && !intVector; endsequence
    property p_lowread; lowReadData == pcOut[7:0]; endproperty
    a_lowread: assert property (p_lowread) else $error("bad low read");
    property p_fetch; fetch && !other && !lowWrite |=> pcOut == $past(pcOut) + 13'h0001; endproperty
    a_fetch: assert property (p_fetch) else $error("no advance");
    property p_jump; jmp |=> pcOut == {$past(latchReadData[4:3]), $past(jumpTarget)}; endproperty
    a_jump: assert property (p_jump) else $error("bad jump");
    property p_low; lowWrite && !other |=> pcOut == {$past(latchReadData[4:0]), $past(lowWriteData)}; endproperty
    a_low: assert property (p_low) else $error("bad low write");
    property p_latch; latchWrite |=> latchReadData == {3'h0, $past(latchWriteData[4:0])}; endproperty
    a_latch: assert property (p_latch) else $error("bad latch");
    property p_keep; !latchWrite && (callDirect || intVector || pop) |=> $stable(latchReadData); endproperty
    a_keep: assert property (p_keep) else $error("latch moved");
    property p_int; intVector |=> pcOut == INT_VECTOR; endproperty
    a_int: assert property (p_int) else $error("bad vector");
    property p_call; s_call |=> pcOut == $past(pcOut, 2) + 13'h0001; endproperty
    a_call: assert property (p_call) else $error("bad return");
    property p_iret; s_int |=> pcOut == $past(pcOut, 2); endproperty
    a_iret: assert property (p_iret) else $error("bad exit");
endmodule // pc_sequencer_checker
bind pc_sequencer pc_sequencer_checker #(.INT_VECTOR(INT_VECTOR)) chk
(
    .clock           (clock),
    .arst_n          (arst_n),
    .fetch           (fetch),
    .jumpDirect      (jumpDirect),
    .callDirect      (callDirect),
    .intVector       (intVector),
    .returnPlain     (returnPlain),
    .literalBackJump (literalBackJump),
    .interruptExit   (interruptExit),
    .lowWrite        (lowWrite),
    .latchWrite      (latchWrite),
    .jumpTarget      (jumpTarget),
    .lowWriteData    (lowWriteData),
    .latchWriteData  (latchWriteData),
    .lowReadData     (lowReadData),
    .latchReadData   (latchReadData),
    .pcOut           (pcOut)
);

// >>> pc_sequencer_tb.sv
// Self-checking testbench for the program counter sequencer.
module pc_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg clock = 1'b0;
    reg arst_n = 1'b0;
    integer fails = 0;
    integer numChecks = 0;
    integer j;
    wire fetch, jumpDirect, callDirect, intVector, returnPlain, literalBackJump, interruptExit;
    wire lowWrite, latchWrite;
    wire [10:0] jumpTarget;
    wire [7:0] lowWriteData, latchWriteData, lowReadData, latchReadData;
    wire [12:0] pcOut;
    always #12.5 clock = ~clock;
    core_decoder_model m
    (
        .clock           (clock),
        .fetch           (fetch),
        .jumpDirect      (jumpDirect),
        .callDirect      (callDirect),
        .intVector       (intVector),
        .returnPlain     (returnPlain),
        .literalBackJump (literalBackJump),
        .interruptExit   (interruptExit),
        .lowWrite        (lowWrite),
        .latchWrite      (latchWrite),
        .jumpTarget      (jumpTarget),
        .lowWriteData    (lowWriteData),
        .latchWriteData  (latchWriteData)
    );
    pc_sequencer uut
    (
        .clock           (clock),
        .arst_n          (arst_n),
        .fetch           (fetch),
        .jumpDirect      (jumpDirect),
        .callDirect      (callDirect),
        .jumpTarget      (jumpTarget),
        .intVector       (intVector),
        .returnPlain     (returnPlain),
        .literalBackJump (literalBackJump),
        .interruptExit   (interruptExit),
        .lowWrite        (lowWrite),
        .lowWriteData    (lowWriteData),
        .latchWrite      (latchWrite),
        .latchWriteData  (latchWriteData),
        .pcOut           (pcOut),
        .lowReadData     (lowReadData),
        .latchReadData   (latchReadData)
    );
    task check(input [12:0] seen, input [12:0] exp);
        numChecks = numChecks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task t_paging;
        m.op(9, 11'h018);
        m.op(2, 11'h123);
        check(pcOut, 13'h1923);
        m.op(8, 11'h045);
        check(pcOut, 13'h1845);
        check({5'h00, lowReadData}, 13'h0045);
    endtask
    task t_wrap;
        m.op(9, 11'h01F);
        m.op(8, 11'h0FF);
        check(pcOut, 13'h1FFF);
        m.op(1, 11'h000);
        check(pcOut, 13'h0000);
        check({5'h00, latchReadData}, 13'h001F);
    endtask
    task t_stack;
        m.op(9, 11'h018);
        for (j = 1; j < 10; j = j + 1)
            m.op(3, j * 16);
        for (j = 1; j < 10; j = j + 1)
        begin
            m.op(5 + (j + 2) % 3, 11'h000);
            check(pcOut, 13'h1801 + 16 * ((j == 9) ? 8 : 9 - j));
        end
        check({5'h00, latchReadData}, 13'h0018);
    endtask
    task t_int;
        m.op(8, 11'h077);
        m.op(4, 11'h000);
        check(pcOut, 13'h0004);
        m.op(7, 11'h000);
        check(pcOut, 13'h1877);
    endtask
    initial
    begin
        repeat (4) @(posedge clock);
        #2 arst_n = 1'b1;
        check(pcOut, 13'h0000);
        t_paging;
        t_wrap;
        t_stack;
        t_int;
        arst_n = 1'b0;
        #1 check(pcOut, 13'h0000);
        end_of_test;
    end
    initial
    begin
        #20000 fails = fails + 1;
        end_of_test;
    end
endmodule // pc_sequencer_tb
